// file: pkg/bem_map.svh
`ifndef BEM_MAP_SVH
`define BEM_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define BEM_ADDR_ENABLE   32'hFF40_0000
`define BEM_ADDR_STAT1    32'hFF40_0004
`define BEM_ADDR_STAT2    32'hFF40_0008
`define BEM_ADDR_NOTIFY   32'hFF40_000C
`define BEM_ADDR_WORD     32'hFFFF_FFFC
`define BEM_RESET_VAL     32'h0000_0000
`define BEM_RESV_MASK     32'hF306_6323

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BEM_EN_CLR_BIT    31
`define BEM_EN_TO_BIT     18
`define BEM_EN_IGA_BIT    17
`define BEM_S1_TO_BIT     14
`define BEM_S1_IL_BIT     13
`define BEM_S1_MST_LSB    8
`define BEM_S2_ETO_BIT    30
`define BEM_S2_EER_BIT    29
`define BEM_S2_EMST_LSB   24
`define BEM_S2_OER_BIT    13
`define BEM_S2_OMST_LSB   8
`define BEM_S2_PERIPH2_ILLEGAL_FLAG_BIT   5
`define BEM_S2_SHMST_LSB  0
`define BEM_NT_CPU_BIT    31
`define BEM_NT_DST_BIT    30
`define BEM_NT_SRC_BIT    28

// ----------------------------------------
// Master codes, bus answers, timing
// ----------------------------------------
`define BEM_MST_CPU       2'h0
`define BEM_MST_DST       2'h1
`define BEM_MST_SRC       2'h3
`define BEM_RESP_OKAY     2'h0
`define BEM_RESP_SLVERR   2'h2
`define BEM_TIMEOUT_CYCLES 1024

// ----------------------------------------
// Address regions
// ----------------------------------------
`define BEM_EXT_HI        32'h4FFF_FFFF
`define BEM_CACHE_LO      32'hF000_0000
`define BEM_CACHE_HI      32'hF5FF_FFFF
`define BEM_P1_LO         32'hFF40_0000
`define BEM_P1_HI         32'hFF5F_FFFF
`define BEM_RAM_LO        32'hFFF8_0000
`define BEM_RAM_HI        32'hFFFB_FFFF
`define BEM_P2_LO         32'hFFFC_0000

`endif

// file: pkg/bem_pkg.sv
`include "bem_map.svh"
`default_nettype none

package bem_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    BEM_RGN_EXT, BEM_RGN_P1, BEM_RGN_P2, BEM_RGN_OTH, BEM_RGN_FREE
  } bem_rgn_t;

  typedef enum logic [2:0] {
    BEM_SEL_EN, BEM_SEL_ST1, BEM_SEL_ST2, BEM_SEL_NTF, BEM_SEL_NONE
  } bem_sel_t;

  typedef enum logic [1:0] {
    BEM_W_IDLE, BEM_W_BUSY, BEM_W_CANCEL
  } bem_wst_t;

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  function automatic bem_rgn_t bem_region(input logic [31:0] a);
    if (a <= `BEM_EXT_HI) begin
      return BEM_RGN_EXT;
    end else if (a >= `BEM_CACHE_LO && a <= `BEM_CACHE_HI) begin
      return BEM_RGN_FREE;
    end else if (a >= `BEM_P1_LO && a <= `BEM_P1_HI) begin
      return BEM_RGN_P1;
    end else if (a >= `BEM_RAM_LO && a <= `BEM_RAM_HI) begin
      return BEM_RGN_FREE;
    end else if (a >= `BEM_P2_LO) begin
      return BEM_RGN_P2;
    end else begin
      return BEM_RGN_OTH;
    end
  endfunction

  function automatic bem_sel_t bem_decode(input logic [31:0] a);
    if ((a & `BEM_ADDR_WORD) == `BEM_ADDR_ENABLE) begin
      return BEM_SEL_EN;
    end else if ((a & `BEM_ADDR_WORD) == `BEM_ADDR_STAT1) begin
      return BEM_SEL_ST1;
    end else if ((a & `BEM_ADDR_WORD) == `BEM_ADDR_STAT2) begin
      return BEM_SEL_ST2;
    end else if ((a & `BEM_ADDR_WORD) == `BEM_ADDR_NOTIFY) begin
      return BEM_SEL_NTF;
    end else begin
      return BEM_SEL_NONE;
    end
  endfunction

endpackage

`default_nettype wire

// file: verilog/bem_watch.sv
`include "bem_map.svh"
`default_nettype none

module bem_watch #(
  parameter int unsigned TIMEOUT_CYCLES = `BEM_TIMEOUT_CYCLES,
  localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1)
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              stby,
  input  wire logic              timeout_detect_en,
  input  wire logic              illegal_access_detect_en,
  input  wire logic              acc_req,
  input  wire logic [31:0]       acc_addr,
  input  wire logic [1:0]        acc_master,
  input  wire logic              acc_ack,
  input  wire logic              acc_decerr,
  output var  logic              evt,
  output var  logic              evt_to,
  output var  logic              evt_il,
  output var  bem_pkg::bem_rgn_t evt_rgn,
  output var  logic [1:0]        evt_mst,
  output var  logic              cancel
);

  // ----------------------------------------
  // Access tracking
  // ----------------------------------------
  bem_pkg::bem_wst_t st_q, st_d;
  bem_pkg::bem_rgn_t rgn_q, rgn_d, cur_rgn, ergn_d;
  logic [1:0]        mst_q, mst_d, cur_mst, emst_d;
  logic [CW-1:0]     cnt_q, cnt_d;
  logic              evt_d, to_d, il_d, cancel_d, il_hit, to_hit;

  always_comb begin
    st_d     = st_q;
    rgn_d    = rgn_q;
    mst_d    = mst_q;
    cnt_d    = cnt_q;
    il_hit   = 1'b0;
    to_hit   = 1'b0;
    cur_rgn  = (st_q == bem_pkg::BEM_W_IDLE) ? bem_pkg::bem_region(acc_addr) : rgn_q;
    cur_mst  = (st_q == bem_pkg::BEM_W_IDLE) ? acc_master : mst_q;
    case (st_q)
      bem_pkg::BEM_W_IDLE: begin
        if (acc_req) begin
          rgn_d  = cur_rgn;
          mst_d  = acc_master;
          cnt_d  = CW'(1);
          il_hit = (cur_rgn == bem_pkg::BEM_RGN_OTH) ||
                   (acc_ack && acc_decerr && cur_rgn != bem_pkg::BEM_RGN_FREE);
          if (!acc_ack) begin
            st_d = bem_pkg::BEM_W_BUSY;
          end
        end
      end
      bem_pkg::BEM_W_BUSY: begin
        // Saturates so a frozen access with detection off never wraps
        if (cnt_q < CW'(TIMEOUT_CYCLES)) begin
          cnt_d = cnt_q + CW'(1);
        end
        if (acc_ack) begin
          st_d   = bem_pkg::BEM_W_IDLE;
          il_hit = acc_decerr && rgn_q != bem_pkg::BEM_RGN_FREE &&
                   rgn_q != bem_pkg::BEM_RGN_OTH;
        end else if (timeout_detect_en && cnt_q >= CW'(TIMEOUT_CYCLES)) begin
          to_hit = 1'b1;
          st_d   = bem_pkg::BEM_W_CANCEL;
        end
      end
      bem_pkg::BEM_W_CANCEL: begin
        if (!acc_req) begin
          st_d = bem_pkg::BEM_W_IDLE;
        end
      end
      default: begin
        st_d = bem_pkg::BEM_W_IDLE;
      end
    endcase
    il_hit   = il_hit && illegal_access_detect_en;
    evt_d    = il_hit || to_hit;
    to_d     = to_hit;
    il_d     = il_hit && !to_hit;
    cancel_d = to_hit;
    ergn_d   = evt_d ? cur_rgn : evt_rgn;
    emst_d   = evt_d ? cur_mst : evt_mst;
    if (stby) begin
      st_d     = bem_pkg::BEM_W_IDLE;
      cnt_d    = '0;
      evt_d    = 1'b0;
      to_d     = 1'b0;
      il_d     = 1'b0;
      cancel_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= bem_pkg::BEM_W_IDLE;
      rgn_q   <= bem_pkg::BEM_RGN_EXT;
      mst_q   <= `BEM_MST_CPU;
      cnt_q   <= '0;
      evt     <= 1'b0;
      evt_to  <= 1'b0;
      evt_il  <= 1'b0;
      evt_rgn <= bem_pkg::BEM_RGN_EXT;
      evt_mst <= `BEM_MST_CPU;
      cancel  <= 1'b0;
    end else begin
      st_q    <= st_d;
      rgn_q   <= rgn_d;
      mst_q   <= mst_d;
      cnt_q   <= cnt_d;
      evt     <= evt_d;
      evt_to  <= to_d;
      evt_il  <= il_d;
      evt_rgn <= ergn_d;
      evt_mst <= emst_d;
      cancel  <= cancel_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_CANCEL_IS_TIMEOUT: assert property (
    @(posedge clk) disable iff (!rst_n) cancel |-> evt && evt_to && !evt_il)
    else $error("cancel without a timeout event");

  AST_TIMEOUT_AGE: assert property (
    @(posedge clk) disable iff (!rst_n)
    cancel |-> $past(st_q) == bem_pkg::BEM_W_BUSY && $past(cnt_q) == CW'(TIMEOUT_CYCLES))
    else $error("timeout at wrong access age");

  AST_TIMEOUT_DETECT_EN_OFF: assert property (
    @(posedge clk) disable iff (!rst_n) cancel |-> $past(timeout_detect_en))
    else $error("timeout while detection disabled");

  AST_IGA_OFF: assert property (
    @(posedge clk) disable iff (!rst_n) evt_il |-> $past(illegal_access_detect_en))
    else $error("illegal access flagged while disabled");

  AST_FREE_NO_ILLEGAL: assert property (
    @(posedge clk) disable iff (!rst_n) evt_il |-> evt_rgn != bem_pkg::BEM_RGN_FREE)
    else $error("illegal access flagged in cache or RAM space");

endmodule

`default_nettype wire

// file: verilog/bem_top.sv
`include "bem_map.svh"
`default_nettype none

// Operation
// - Enabled detector finding illegal access or timeout raises bus error interrupt
// - A timeout also pulses the access-cancel output
// - Power-on reset or deep standby returns every register to zero
// - Writing one to status-clear empties status; zero or reading does nothing
// - Timeout-detect enable switches timeout detection; resets off
// - Illegal-access-detect enable switches illegal detection; resets off
// - Peripheral-one timeout flag shows first error was a timeout there
// - Peripheral-one illegal flag shows first error was illegal access there
// - Master field: 00 CPU, 01 DMA destination, 11 DMA source
// - Addresses up to 4FFF_FFFF belong to the external bus
// - FF40_0000 to FF5F_FFFF belong to peripheral bus one
// - FFFC_0000 upward belongs to peripheral bus two
// - Other reserved space belongs to the others bus
// - Cache and RAM space never give illegal errors; adjoining reserved space does
// - Reserved bits read zero; software writes zero
// - Second status holds external, peripheral-two and others first error
// - Per-master notify enables gate reporting; reset to not notified
module bem_top #(
  parameter int unsigned TIMEOUT_CYCLES = `BEM_TIMEOUT_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        DEEP_STANDBY,
  input  wire logic        ACC_REQ,
  input  wire logic [31:0] ACC_ADDR,
  input  wire logic [1:0]  ACC_MASTER,
  input  wire logic        ACC_ACK,
  input  wire logic        ACC_DECERR,
  output var  logic        ACC_CANCEL,
  output var  logic        BUS_ERR_IRQ,
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  output var  logic [1:0]  S_AXI_BRESP,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // ----------------------------------------
  // Access watcher
  // ----------------------------------------
  logic              w_evt, w_to, w_il;
  bem_pkg::bem_rgn_t w_rgn;
  logic [1:0]        w_mst;
  logic              timeout_detect_en_q, illegal_access_detect_en_q;

  bem_watch #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_watch (
    .clk        (CLK),
    .rst_n      (RST_N),
    .stby       (DEEP_STANDBY),
    .timeout_detect_en       (timeout_detect_en_q),
    .illegal_access_detect_en      (illegal_access_detect_en_q),
    .acc_req    (ACC_REQ),
    .acc_addr   (ACC_ADDR),
    .acc_master (ACC_MASTER),
    .acc_ack    (ACC_ACK),
    .acc_decerr (ACC_DECERR),
    .evt        (w_evt),
    .evt_to     (w_to),
    .evt_il     (w_il),
    .evt_rgn    (w_rgn),
    .evt_mst    (w_mst),
    .cancel     (ACC_CANCEL)
  );

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic              aw_pend_q, aw_pend_d, w_pend_q, w_pend_d;
  logic [31:0]       awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d, rd_word;
  logic              wr_go;
  bem_pkg::bem_sel_t wsel, rsel;

  assign S_AXI_AWREADY = !aw_pend_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_pend_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = rdata_q;
  assign wsel          = bem_pkg::bem_decode(awaddr_q);
  assign rsel          = bem_pkg::bem_decode(S_AXI_ARADDR);
  // Write executes only once both halves are held, one cycle after the later
  assign wr_go         = aw_pend_q && w_pend_q && !bvalid_q;

  always_comb begin
    aw_pend_d = aw_pend_q;
    awaddr_d  = awaddr_q;
    w_pend_d  = w_pend_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_pend_d = 1'b1;
      awaddr_d  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_pend_d = 1'b1;
      wdata_d  = S_AXI_WDATA;
      wstrb_d  = S_AXI_WSTRB;
    end
    if (wr_go) begin
      aw_pend_d = 1'b0;
      w_pend_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wsel == bem_pkg::BEM_SEL_NONE) ? `BEM_RESP_SLVERR : `BEM_RESP_OKAY;
    end else if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_word;
      rresp_d  = (rsel == bem_pkg::BEM_SEL_NONE) ? `BEM_RESP_SLVERR : `BEM_RESP_OKAY;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_pend_q <= 1'b0;
      awaddr_q  <= `BEM_RESET_VAL;
      w_pend_q  <= 1'b0;
      wdata_q   <= `BEM_RESET_VAL;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `BEM_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= `BEM_RESP_OKAY;
      rdata_q   <= `BEM_RESET_VAL;
    end else begin
      aw_pend_q <= aw_pend_d;
      awaddr_q  <= awaddr_d;
      w_pend_q  <= w_pend_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic       timeout_detect_en_d, illegal_access_detect_en_d, clr;
  logic [2:0] ntf_q, ntf_d;

  always_comb begin
    timeout_detect_en_d  = timeout_detect_en_q;
    illegal_access_detect_en_d = illegal_access_detect_en_q;
    ntf_d   = ntf_q;
    clr     = 1'b0;
    if (wr_go && wsel == bem_pkg::BEM_SEL_EN) begin
      if (wstrb_q[2]) begin
        timeout_detect_en_d  = wdata_q[`BEM_EN_TO_BIT];
        illegal_access_detect_en_d = wdata_q[`BEM_EN_IGA_BIT];
      end
      clr = wstrb_q[3] && wdata_q[`BEM_EN_CLR_BIT];
    end
    if (wr_go && wsel == bem_pkg::BEM_SEL_NTF && wstrb_q[3]) begin
      ntf_d = {wdata_q[`BEM_NT_SRC_BIT], wdata_q[`BEM_NT_DST_BIT],
               wdata_q[`BEM_NT_CPU_BIT]};
    end
    if (DEEP_STANDBY) begin
      timeout_detect_en_d  = 1'b0;
      illegal_access_detect_en_d = 1'b0;
      ntf_d   = 3'h0;
      clr     = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      timeout_detect_en_q  <= 1'b0;
      illegal_access_detect_en_q <= 1'b0;
      ntf_q   <= 3'h0;
    end else begin
      timeout_detect_en_q  <= timeout_detect_en_d;
      illegal_access_detect_en_q <= illegal_access_detect_en_d;
      ntf_q   <= ntf_d;
    end
  end

  // ----------------------------------------
  // First-error capture and interrupt
  // ----------------------------------------
  logic              cap_v_q, cap_v_d, cap_to_q, cap_to_d, cap_il_q, cap_il_d;
  logic [1:0]        cap_mst_q, cap_mst_d;
  bem_pkg::bem_rgn_t cap_rgn_q, cap_rgn_d;
  logic              irq_d, ntf_hit;

  always_comb begin
    cap_v_d   = cap_v_q;
    cap_to_d  = cap_to_q;
    cap_il_d  = cap_il_q;
    cap_mst_d = cap_mst_q;
    cap_rgn_d = cap_rgn_q;
    if (clr) begin
      cap_v_d   = 1'b0;
      cap_to_d  = 1'b0;
      cap_il_d  = 1'b0;
      cap_mst_d = `BEM_MST_CPU;
      cap_rgn_d = bem_pkg::BEM_RGN_EXT;
    end
    // A new error in the clearing cycle wins over the clear
    if (w_evt && (!cap_v_q || clr) && !DEEP_STANDBY) begin
      cap_v_d   = 1'b1;
      cap_to_d  = w_to;
      cap_il_d  = w_il;
      cap_mst_d = w_mst;
      cap_rgn_d = w_rgn;
    end
    case (cap_mst_d)
      `BEM_MST_CPU: ntf_hit = ntf_d[0];
      `BEM_MST_DST: ntf_hit = ntf_d[1];
      `BEM_MST_SRC: ntf_hit = ntf_d[2];
      default:      ntf_hit = 1'b0;
    endcase
    irq_d = cap_v_d && ntf_hit;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_v_q     <= 1'b0;
      cap_to_q    <= 1'b0;
      cap_il_q    <= 1'b0;
      cap_mst_q   <= `BEM_MST_CPU;
      cap_rgn_q   <= bem_pkg::BEM_RGN_EXT;
      BUS_ERR_IRQ <= 1'b0;
    end else begin
      cap_v_q     <= cap_v_d;
      cap_to_q    <= cap_to_d;
      cap_il_q    <= cap_il_d;
      cap_mst_q   <= cap_mst_d;
      cap_rgn_q   <= cap_rgn_d;
      BUS_ERR_IRQ <= irq_d;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rd_word = `BEM_RESET_VAL;
    if (rsel == bem_pkg::BEM_SEL_EN) begin
      rd_word[`BEM_EN_TO_BIT]  = timeout_detect_en_q;
      rd_word[`BEM_EN_IGA_BIT] = illegal_access_detect_en_q;
    end else if (rsel == bem_pkg::BEM_SEL_ST1) begin
      if (cap_rgn_q == bem_pkg::BEM_RGN_P1) begin
        rd_word[`BEM_S1_TO_BIT] = cap_to_q;
        rd_word[`BEM_S1_IL_BIT] = cap_il_q;
        rd_word[`BEM_S1_MST_LSB +: 2] = cap_mst_q;
      end
    end else if (rsel == bem_pkg::BEM_SEL_ST2) begin
      if (cap_rgn_q == bem_pkg::BEM_RGN_EXT) begin
        rd_word[`BEM_S2_ETO_BIT] = cap_to_q;
        rd_word[`BEM_S2_EER_BIT] = cap_il_q;
        rd_word[`BEM_S2_EMST_LSB +: 2] = cap_mst_q;
      end else if (cap_rgn_q == bem_pkg::BEM_RGN_OTH) begin
        rd_word[`BEM_S2_OER_BIT] = cap_il_q;
        rd_word[`BEM_S2_OMST_LSB +: 2] = cap_mst_q;
      end else if (cap_rgn_q == bem_pkg::BEM_RGN_P2) begin
        rd_word[`BEM_S2_PERIPH2_ILLEGAL_FLAG_BIT] = cap_il_q;
        rd_word[`BEM_S2_SHMST_LSB +: 2] = cap_mst_q;
      end
    end else if (rsel == bem_pkg::BEM_SEL_NTF) begin
      rd_word[`BEM_NT_CPU_BIT] = ntf_q[0];
      rd_word[`BEM_NT_DST_BIT] = ntf_q[1];
      rd_word[`BEM_NT_SRC_BIT] = ntf_q[2];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_STANDBY_CLEARS: assert property (
    @(posedge CLK) disable iff (!RST_N)
    DEEP_STANDBY |=> !timeout_detect_en_q && !illegal_access_detect_en_q && ntf_q == 3'h0 && !cap_v_q && !BUS_ERR_IRQ)
    else $error("deep standby left state behind");

  AST_CLEAR_EMPTIES: assert property (
    @(posedge CLK) disable iff (!RST_N)
    clr && !w_evt |=> !cap_v_q && !BUS_ERR_IRQ ##1 !BUS_ERR_IRQ || cap_v_q)
    else $error("status clear did not empty status");

  AST_FIRST_HELD: assert property (
    @(posedge CLK) disable iff (!RST_N)
    cap_v_q && !clr |=> cap_v_q && $stable(cap_mst_q) && $stable(cap_rgn_q)
                        && $stable(cap_to_q) && $stable(cap_il_q))
    else $error("first error overwritten");

  AST_IRQ_RAISED: assert property (
    @(posedge CLK) disable iff (!RST_N)
    w_evt && !cap_v_q && !DEEP_STANDBY && !wr_go && w_mst == `BEM_MST_CPU && ntf_q[0]
    |=> BUS_ERR_IRQ ##1 (BUS_ERR_IRQ || $past(clr) || $past(DEEP_STANDBY) || $past(wr_go)))
    else $error("notified error raised no interrupt");

  AST_IRQ_NEEDS_ENABLE: assert property (
    @(posedge CLK) disable iff (!RST_N)
    BUS_ERR_IRQ |-> cap_v_q && ntf_q != 3'h0)
    else $error("interrupt without captured, notified error");

  AST_RESERVED_ZERO: assert property (
    @(posedge CLK) disable iff (!RST_N)
    S_AXI_RVALID |-> (S_AXI_RDATA & ~`BEM_RESV_MASK) == `BEM_RESET_VAL)
    else $error("reserved bits read nonzero");

endmodule

`default_nettype wire

// file: verification/bem_far.sv
`default_nettype none

// ----------------------------------------
// Bus master and slave on the watched bus
// ----------------------------------------
module bem_far (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [31:0] a,
  input  wire logic [1:0]  m,
  input  wire logic [7:0]  d,
  input  wire logic        de,
  input  wire logic        cancel,
  output var  logic        req,
  output var  logic [31:0] addr,
  output var  logic [1:0]  mst,
  output var  logic        ack,
  output var  logic        decerr,
  output var  logic        busy,
  output var  logic [7:0]  n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {req, ack, decerr, busy} = 4'h0;
    {addr, mst, n} = '0;
  end
  // Decerr means nothing off an ack, so it toggles
  always @(posedge clk) begin
    ack <= 1'b0;
    decerr <= ~decerr;
    if (!busy) begin
      if (go) begin
        {busy, req, addr, mst, n} <= {2'h3, a, m, 8'h00};
        ack <= (d == 8'h00);
        decerr <= de;
      end
    end else if (ack || cancel) begin
      // Lets go on cancel; released lines turn over
      {busy, req, addr, mst} <= {2'h0, ~addr, ~mst};
    end else begin
      n <= n + 8'h01;
      if (n + 8'h01 == d) begin
        ack <= 1'b1;
        decerr <= de;
      end
    end
  end
endmodule

`default_nettype wire

// file: verification/bus_error_monitor_bench.sv
`include "bem_map.svh"
`default_nettype none

module bus_error_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          TO = 8;
  localparam logic [31:0] EN = `BEM_ADDR_ENABLE;
  localparam logic [31:0] S1 = `BEM_ADDR_STAT1;
  localparam logic [31:0] S2 = `BEM_ADDR_STAT2;
  localparam logic [31:0] NT = `BEM_ADDR_NOTIFY;
  localparam logic [31:0] Z  = `BEM_RESET_VAL;
  localparam logic [1:0]  OK = `BEM_RESP_OKAY;
  localparam logic [1:0]  SE = `BEM_RESP_SLVERR;
  typedef struct {
    logic [31:0] a;
    logic [1:0]  m;
    logic [7:0]  d;
    logic        de;
    logic [31:0] s1;
    logic [31:0] s2;
  } bem_row_t;
  logic        clk, rst_n = 1'b0, stby = 1'b0, go = 1'b0, de = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [31:0] aw = '0, wd = '0, ar = '0, a = '0, fa, rdata;
  logic [1:0]  m = '0, fm, br, rr;
  logic [7:0]  d = '0, n;
  logic [3:0]  ws = 4'hF;
  logic        req, ack, der, cancel, irq, awr, wrd, bv, arr, rv, busy;
  int          fail_count = 0, tests_run = 0;
  // Hang rows use FF; cancel comes at TO plus one
  bem_row_t rows [12] = '{
    '{32'hFF40_0100, 2'h0, 8'hFF, 1'b0, 32'h0000_4000, Z},
    '{32'hFF40_0100, 2'h3, 8'h02, 1'b1, 32'h0000_2300, Z},
    '{32'h1000_0000, 2'h1, 8'hFF, 1'b0, Z, 32'h4100_0000},
    '{32'h4FFF_FFFC, 2'h3, 8'h00, 1'b1, Z, 32'h2300_0000},
    '{32'h5000_0000, 2'h1, 8'h01, 1'b0, Z, 32'h0000_2100},
    '{32'hFF3F_FFFC, 2'h3, 8'h01, 1'b0, Z, 32'h0000_2300},
    '{32'hFFF7_FFFC, 2'h0, 8'h01, 1'b0, Z, 32'h0000_2000},
    '{32'hFFFC_0000, 2'h0, 8'h03, 1'b1, Z, 32'h0000_0020},
    '{32'hF000_0000, 2'h0, 8'h01, 1'b1, Z, Z},
    '{32'hFFF8_8000, 2'h0, 8'h01, 1'b1, Z, Z},
    '{32'hFF40_0000, 2'h0, 8'h08, 1'b0, Z, Z},
    '{32'hFFFF_FFFC, 2'h1, 8'hFF, 1'b0, Z, 32'h0000_0001}
  };

  bem_top #(.TIMEOUT_CYCLES(TO)) i_dut (
    .CLK(clk), .RST_N(rst_n), .DEEP_STANDBY(stby), .ACC_REQ(req),
    .ACC_ADDR(fa), .ACC_MASTER(fm), .ACC_ACK(ack), .ACC_DECERR(der),
    .ACC_CANCEL(cancel), .BUS_ERR_IRQ(irq), .S_AXI_AWADDR(aw),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry)
  );

  bem_far i_far (
    .clk(clk), .go(go), .a(a), .m(m), .d(d), .de(de), .cancel(cancel),
    .req(req), .addr(fa), .mst(fm), .ack(ack), .decerr(der),
    .busy(busy), .n(n)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic hung();
    fail_count++;
    results();
  endtask

  task automatic wr(input logic [31:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int i;
    @(posedge clk);
    {aw, wd, awv, wv, bry} <= {ad, dt, 3'h7};
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    if (i == 50) hung();
    bry <= 1'b0;
    chk("bresp", 32'(br), 32'(er));
  endtask

  task automatic rd(input logic [31:0] ad, input logic [31:0] ex, input logic [1:0] er);
    int i;
    @(posedge clk);
    {ar, arv, rry} <= {ad, 2'h3};
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    if (i == 50) hung();
    rry <= 1'b0;
    chk("rdata", rdata, ex);
    chk("rresp", 32'(rr), 32'(er));
  endtask

  task automatic acc(input bem_row_t r);
    int i;
    @(posedge clk);
    {a, m, d, de, go} <= {r.a, r.m, r.d, r.de, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (!busy) break;
    end
    if (i == 60) hung();
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) rd(EN + 32'(4 * k), Z, OK);
    rd(32'hFF40_0010, Z, SE);
    wr(32'hFF40_0010, 32'hFFFF_FFFF, SE);
    wr(EN, 32'h8006_0000, OK);
    rd(EN, 32'h0006_0000, OK);
    wr(NT, 32'hD000_0000, OK);
    rd(NT, 32'hD000_0000, OK);
    wr(S1, 32'h0000_6300, OK);
    rd(S1, Z, OK);
    $display("test reset and registers done");
    foreach (rows[k]) begin
      wr(EN, 32'h8006_0000, OK);
      acc(rows[k]);
      chk("cycles", 32'(n), (rows[k].d == 8'hFF) ? 32'(TO + 1) : 32'(rows[k].d));
      rd(S1, rows[k].s1, OK);
      rd(S2, rows[k].s2, OK);
      chk("irq", 32'(irq), 32'((rows[k].s1 | rows[k].s2) != Z));
    end
    $display("test table done");
    // Second error must not displace the first
    acc('{32'hFF40_0100, 2'h0, 8'h02, 1'b1, Z, Z});
    rd(S1, Z, OK);
    rd(S2, 32'h0000_0001, OK);
    wr(EN, 32'h0006_0000, OK);
    rd(S2, 32'h0000_0001, OK);
    wr(NT, 32'h9000_0000, OK);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), Z);
    $display("test hold done");
    stby <= 1'b1;
    repeat (2) @(posedge clk);
    stby <= 1'b0;
    rd(EN, Z, OK);
    rd(S2, Z, OK);
    rd(NT, Z, OK);
    // Enable byte masked off: enables must stay off
    ws <= 4'h3;
    wr(EN, 32'h0006_0000, OK);
    rd(EN, Z, OK);
    ws <= 4'hF;
    acc('{32'hFF40_0100, 2'h0, 8'h02, 1'b1, Z, Z});
    rd(S1, Z, OK);
    acc('{32'hFF40_0100, 2'h0, 8'h0C, 1'b0, Z, Z});
    chk("cycles", 32'(n), 32'h0000_000C);
    rd(S1, Z, OK);
    $display("test standby and disable done");
    results();
  end
endmodule

`default_nettype wire
